/* hdl/swbs_pkg.sv */
// package for the speed window and brake sequencer
// assumes a fieldbus parameter port with word offsets as printed
package swbs_pkg;
    // parameter addresses (fieldbus word offsets)
    localparam logic [15:0] ADDR_BRAKE_OPEN = 16'h050E;
    localparam logic [15:0] ADDR_BRAKE_CLOSE = 16'h0510;
    localparam logic [15:0] ADDR_SPEED_TOL = 16'h0628;
    localparam logic [15:0] ADDR_SETTLE_TIME = 16'h062A;
    localparam logic [15:0] ADDR_SETTLE_MOVE = 16'h1410;
    localparam logic [15:0] ADDR_CURRENT = 16'h1E28;
    // reset values and limits
    localparam logic [15:0] RST_BRAKE_OPEN = 16'h0000;
    localparam logic [15:0] RST_BRAKE_CLOSE = 16'h0064;
    localparam logic [15:0] RST_SPEED_TOL = 16'h001E;
    localparam logic [15:0] RST_SETTLE_TIME = 16'h0000;
    localparam logic [15:0] RST_SETTLE_MOVE = 16'h0001;
    localparam logic [15:0] MIN_SPEED_TOL = 16'h0001;
    localparam logic [15:0] MAX_SETTLE_TIME = 16'h3FFF;
    localparam logic [15:0] MAX_BRAKE_DELAY = 16'h03E8;
    // timing: one millisecond tick at 250 MHz
    localparam int CLK_MHZ = 250;
    localparam int TICK_US = 1000;
    localparam int TICK_CYCLES = TICK_US * CLK_MHZ;
    localparam int SETTLE_MOVE_MS = 2;

    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [15:0] addr;
        logic [15:0] wdata;
    } swbs_req_t;

    typedef struct packed {
        logic        ack;
        logic        err;
        logic [15:0] rdata;
    } swbs_rsp_t;
endpackage

/* hdl/swbs_top.sv */
// speed window monitor and holding brake sequencer
// assumes a same-clock parameter port; only the sto pin input is synchronised here, the panel pulses are not
`timescale 1ns/1ps
// What this block does
// - speed reached only after deviation stays in band for whole window time
// - tolerance is 16-bit rpm, 1 to 65535, default 30
// - window time 0 to 16383 ms; zero disables monitoring
// - writing a changed window time restarts monitoring and clears reached
// - on enable, release brake first, enable stage after release delay
// - release delay 0 to 1000 ms, default 0
// - on disable, apply brake at once, keep current for apply delay
// - apply delay 0 to 1000 ms, default 100
// - safe torque off skips apply delay, removes current at once
// - manual brake commands accepted only while stage disabled
// - settling option 1 gives small move at activation, 0 none
module swbs_top #(
    parameter int TICK_CYCLES = swbs_pkg::TICK_CYCLES
) (
    input wire logic i_clk,                        // 250 MHz clock
    input wire logic i_rst,                        // sync reset, high
    input wire swbs_pkg::swbs_req_t i_req,         // parameter access
    output swbs_pkg::swbs_rsp_t o_rsp,             // access answer
    input wire logic [16:0] i_speed_dev,           // |ref-actual| rpm
    input wire logic [15:0] i_current,             // motor current 0.01A
    input wire logic i_enable_req,                 // stage enable request
    input wire logic i_safe_torque_off,            // pin, active high
    input wire logic i_manual_release,             // panel pulse
    input wire logic i_manual_apply,               // panel pulse
    output logic o_speed_reached,                  // level
    output logic o_brake_release,                  // 1 = brake open
    output logic o_stage_enable,                   // motor current on
    output logic o_settle_move,                    // settling move active
    output logic o_stage_active                    // sequencer not idle
);
    typedef enum logic [2:0] {
        SWBS_IDLE, SWBS_OPENING, SWBS_SETTLE, SWBS_RUN, SWBS_CLOSING
    } swbs_state_t;

    // sto pin synchroniser, only the second stage is read
    logic sto_meta_q, sto_q;
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            sto_meta_q <= 1'b0;
            sto_q <= 1'b0;
        end else begin
            sto_meta_q <= i_safe_torque_off;
            sto_q <= sto_meta_q;
        end
    end

    // millisecond tick; all delays count whole ticks, so a delay is -1/+0 ms
    logic [31:0] pre_q, pre_d;
    logic tick_q, tick_d;
    always_comb begin
        pre_d = pre_q + 32'h1;
        tick_d = 1'b0;
        if (pre_q == 32'(TICK_CYCLES - 1)) begin
            pre_d = 32'h0;
            tick_d = 1'b1;
        end
    end
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            pre_q <= 32'h0;
            tick_q <= 1'b0;
        end else begin
            pre_q <= pre_d;
            tick_q <= tick_d;
        end
    end

    // parameter registers and bus answers
    logic [15:0] open_q, open_d, close_q, close_d, tol_q, tol_d;
    logic [15:0] wtime_q, wtime_d, cur_q, cur_d;
    logic move_q, move_d, restart_q, restart_d;
    swbs_pkg::swbs_rsp_t rsp_q, rsp_d;
    always_comb begin
        open_d = open_q;
        close_d = close_q;
        tol_d = tol_q;
        wtime_d = wtime_q;
        move_d = move_q;
        cur_d = i_current;
        restart_d = 1'b0;
        rsp_d = '0;
        rsp_d.ack = i_req.wr | i_req.rd;
        if (i_req.wr) begin
            // out-of-range writes are refused and keep the old value
            unique case (i_req.addr)
                swbs_pkg::ADDR_BRAKE_OPEN: begin
                    if (i_req.wdata <= swbs_pkg::MAX_BRAKE_DELAY) open_d = i_req.wdata;
                    else rsp_d.err = 1'b1;
                end
                swbs_pkg::ADDR_BRAKE_CLOSE: begin
                    if (i_req.wdata <= swbs_pkg::MAX_BRAKE_DELAY) close_d = i_req.wdata;
                    else rsp_d.err = 1'b1;
                end
                swbs_pkg::ADDR_SPEED_TOL: begin
                    if (i_req.wdata >= swbs_pkg::MIN_SPEED_TOL) tol_d = i_req.wdata;
                    else rsp_d.err = 1'b1;
                end
                swbs_pkg::ADDR_SETTLE_TIME: begin
                    if (i_req.wdata <= swbs_pkg::MAX_SETTLE_TIME) begin
                        wtime_d = i_req.wdata;
                        restart_d = (i_req.wdata != wtime_q);
                    end else rsp_d.err = 1'b1;
                end
                swbs_pkg::ADDR_SETTLE_MOVE: begin
                    if (i_req.wdata <= 16'h0001) move_d = i_req.wdata[0];
                    else rsp_d.err = 1'b1;
                end
                default: rsp_d.err = 1'b1; // unmapped or read-only
            endcase
        end else if (i_req.rd) begin
            unique case (i_req.addr)
                swbs_pkg::ADDR_BRAKE_OPEN: rsp_d.rdata = open_q;
                swbs_pkg::ADDR_BRAKE_CLOSE: rsp_d.rdata = close_q;
                swbs_pkg::ADDR_SPEED_TOL: rsp_d.rdata = tol_q;
                swbs_pkg::ADDR_SETTLE_TIME: rsp_d.rdata = wtime_q;
                swbs_pkg::ADDR_SETTLE_MOVE: rsp_d.rdata = {15'h0000, move_q};
                swbs_pkg::ADDR_CURRENT: rsp_d.rdata = cur_q;
                default: rsp_d.err = 1'b1;
            endcase
        end
    end
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            open_q <= swbs_pkg::RST_BRAKE_OPEN;
            close_q <= swbs_pkg::RST_BRAKE_CLOSE;
            tol_q <= swbs_pkg::RST_SPEED_TOL;
            wtime_q <= swbs_pkg::RST_SETTLE_TIME;
            move_q <= swbs_pkg::RST_SETTLE_MOVE[0];
            cur_q <= 16'h0000;
            restart_q <= 1'b0;
            rsp_q <= '0;
        end else begin
            open_q <= open_d;
            close_q <= close_d;
            tol_q <= tol_d;
            wtime_q <= wtime_d;
            move_q <= move_d;
            cur_q <= cur_d;
            restart_q <= restart_d;
            rsp_q <= rsp_d;
        end
    end
    assign o_rsp = rsp_q;

    // speed window qualification
    logic [13:0] win_q, win_d;
    logic reached_q, reached_d, in_band;
    always_comb begin
        in_band = (i_speed_dev <= {1'b0, tol_q});
        win_d = win_q;
        reached_d = reached_q;
        if (wtime_q == 16'h0000 || restart_q || !in_band) begin
            win_d = 14'h0000;
            reached_d = 1'b0;
        end else if (tick_q && !reached_q) begin
            // reached only once the whole window has elapsed in band
            win_d = win_q + 14'h0001;
            if ({2'b00, win_d} >= wtime_q) reached_d = 1'b1;
        end
    end
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            win_q <= 14'h0000;
            reached_q <= 1'b0;
        end else begin
            win_q <= win_d;
            reached_q <= reached_d;
        end
    end

    // brake and power stage sequencer
    swbs_state_t st_q, st_d;
    logic [15:0] dly_q, dly_d;
    logic brk_q, brk_d, en_q, en_d, mv_q, mv_d;
    always_comb begin
        st_d = st_q;
        dly_d = dly_q;
        brk_d = brk_q;
        en_d = en_q;
        mv_d = 1'b0;
        if (tick_q && dly_q != 16'h0000) dly_d = dly_q - 16'h0001;
        unique case (st_q)
            SWBS_IDLE: begin
                en_d = 1'b0;
                // panel commands honoured only with the stage off
                if (i_manual_release) brk_d = 1'b1;
                else if (i_manual_apply) brk_d = 1'b0;
                if (i_enable_req && !sto_q) begin
                    brk_d = 1'b1;
                    dly_d = open_q;
                    st_d = SWBS_OPENING;
                end
            end
            SWBS_OPENING: begin
                if (!i_enable_req || sto_q) begin
                    brk_d = 1'b0;
                    st_d = SWBS_IDLE;
                end else if (dly_q == 16'h0000) begin
                    en_d = 1'b1;
                    dly_d = 16'(swbs_pkg::SETTLE_MOVE_MS);
                    st_d = move_q ? SWBS_SETTLE : SWBS_RUN;
                end
            end
            SWBS_SETTLE: begin
                mv_d = 1'b1;
                if (dly_q == 16'h0000) st_d = SWBS_RUN;
                // move flag drops with the exit so it never outlives stage or brake
                if (sto_q) begin
                    brk_d = 1'b0;
                    en_d = 1'b0;
                    mv_d = 1'b0;
                    st_d = SWBS_IDLE;
                end else if (!i_enable_req) begin
                    brk_d = 1'b0;
                    mv_d = 1'b0;
                    dly_d = close_q;
                    st_d = SWBS_CLOSING;
                end
            end
            SWBS_RUN: begin
                if (sto_q) begin
                    brk_d = 1'b0;
                    en_d = 1'b0;
                    st_d = SWBS_IDLE;
                end else if (!i_enable_req) begin
                    brk_d = 1'b0;
                    dly_d = close_q;
                    st_d = SWBS_CLOSING;
                end
            end
            SWBS_CLOSING: begin
                // sto cuts current even mid-delay
                if (sto_q || dly_q == 16'h0000) begin
                    en_d = 1'b0;
                    st_d = SWBS_IDLE;
                end
            end
            default: st_d = SWBS_IDLE;
        endcase
    end
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            st_q <= SWBS_IDLE;
            dly_q <= 16'h0000;
            brk_q <= 1'b0;
            en_q <= 1'b0;
            mv_q <= 1'b0;
        end else begin
            st_q <= st_d;
            dly_q <= dly_d;
            brk_q <= brk_d;
            en_q <= en_d;
            mv_q <= mv_d;
        end
    end

    // status outputs, from flip-flops
    logic act_q;
    always_ff @(posedge i_clk) begin
        if (i_rst) act_q <= 1'b0;
        else act_q <= (st_d != SWBS_IDLE);
    end
    assign o_speed_reached = reached_q;
    assign o_brake_release = brk_q;
    assign o_stage_enable = en_q;
    assign o_settle_move = mv_q;
    assign o_stage_active = act_q;
endmodule

/* sim/speed_window_brake_sequencer_test.sv */
// self-checking bench for the speed window and brake sequencer
// assumes a ten-clock tick, so one millisecond is ten cycles
`timescale 1ns/1ps
module speed_window_brake_sequencer_test;
    localparam int SR = 4, BR = 3, SE = 2, SM = 1, ST = 0;
    localparam logic [15:0] OPN = swbs_pkg::ADDR_BRAKE_OPEN;
    localparam logic [15:0] CLS = swbs_pkg::ADDR_BRAKE_CLOSE;
    localparam logic [15:0] TOL = swbs_pkg::ADDR_SPEED_TOL;
    localparam logic [15:0] WIN = swbs_pkg::ADDR_SETTLE_TIME;
    localparam logic [15:0] MOV = swbs_pkg::ADDR_SETTLE_MOVE;
    localparam logic [15:0] CUR = swbs_pkg::ADDR_CURRENT;
    logic i_clk = 1'b0;
    logic i_rst = 1'b1;
    swbs_pkg::swbs_req_t i_req = '0;
    swbs_pkg::swbs_rsp_t o_rsp;
    logic [16:0] dev_cmd = 17'h00000;
    logic [16:0] i_speed_dev;
    logic [15:0] i_current;
    logic i_enable_req = 1'b0;
    logic i_safe_torque_off = 1'b0;
    logic i_manual_release = 1'b0;
    logic i_manual_apply = 1'b0;
    logic o_speed_reached, o_brake_release, o_stage_enable, o_settle_move, o_stage_active;
    logic [4:0] outs;
    logic [17:0] expq[$];
    logic [17:0] nt;
    logic [15:0] r;
    int num_errors = 0;
    int n_tests = 0;
    assign outs = {o_speed_reached, o_brake_release, o_stage_enable, o_settle_move,
        o_stage_active};
    always #2 i_clk = ~i_clk;
    swbs_top #(.TICK_CYCLES(10)) swbs_top_inst (.i_clk(i_clk), .i_rst(i_rst), .i_req(i_req),
        .o_rsp(o_rsp), .i_speed_dev(i_speed_dev), .i_current(i_current),
        .i_enable_req(i_enable_req), .i_safe_torque_off(i_safe_torque_off),
        .i_manual_release(i_manual_release), .i_manual_apply(i_manual_apply),
        .o_speed_reached(o_speed_reached), .o_brake_release(o_brake_release),
        .o_stage_enable(o_stage_enable), .o_settle_move(o_settle_move),
        .o_stage_active(o_stage_active));
    swbs_stage_model swbs_stage_model_inst (.i_clk(i_clk), .i_stage_enable(o_stage_enable),
        .i_brake_release(o_brake_release), .i_dev_cmd(dev_cmd), .o_speed_dev(i_speed_dev),
        .o_current(i_current));
    task automatic check(input logic [16:0] seen, input logic [16:0] exp);
        n_tests++;
        if (seen !== exp) begin
            num_errors++;
            $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic finish_test();
        $display("errors %0d checks %0d", num_errors, n_tests);
        if (num_errors == 0 && n_tests > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    // note goes in first; second negedge avoids a double drive of the strobe
    task automatic acc(input logic rd, input logic [15:0] a, input logic [15:0] d, input logic e);
        expq.push_back({rd, e, d});
        i_req = '{wr: !rd, rd: rd, addr: a, wdata: rd ? 16'h0000 : d};
        @(negedge i_clk);
        i_req = '0;
        @(negedge i_clk);
    endtask
    task automatic wait_out(input int s, input logic v, input int n);
        int k;
        k = 0;
        while (outs[s] !== v) begin
            if (k == n) begin
                num_errors++;
                $display("MISMATCH t=%0t output %0d timed out", $time, s);
                finish_test();
            end
            k++;
            @(negedge i_clk);
        end
        check({16'h0, outs[s]}, {16'h0, v});
    endtask
    task automatic hold(input int s, input logic v, input int n);
        repeat (n) begin
            check({16'h0, outs[s]}, {16'h0, v});
            @(negedge i_clk);
        end
    endtask
    task automatic pulse(input logic rel);
        if (rel) i_manual_release = 1'b1;
        else i_manual_apply = 1'b1;
        @(negedge i_clk);
        // only the raised line is dropped, so a following pulse never double-drives
        if (rel) i_manual_release = 1'b0;
        else i_manual_apply = 1'b0;
    endtask
    // answers are matched in order against the oldest note
    always @(negedge i_clk) begin
        if (o_rsp.ack === 1'b1) begin
            if (expq.size() == 0) check(17'h00001, 17'h00000);
            else begin
                nt = expq.pop_front();
                check({16'h0, o_rsp.err}, {16'h0, nt[16]});
                if (nt[17]) check({1'b0, o_rsp.rdata}, {1'b0, nt[15:0]});
            end
        end
    end
    initial begin
        void'($urandom(32'h3E6C7E13));
        repeat (12) @(negedge i_clk);
        i_rst = 1'b0;
        // refused writes first, so the default reads prove nothing changed
        acc(0, TOL, 16'h0000, 1);
        acc(0, WIN, 16'h4000, 1);
        acc(0, OPN, 16'h03E9, 1);
        acc(0, CLS, 16'h03E9, 1);
        acc(0, MOV, 16'h0002, 1);
        acc(0, CUR, 16'h0001, 1);
        acc(0, 16'h0001, 16'h0000, 1);
        acc(1, 16'h0001, 16'h0000, 1);
        acc(1, OPN, swbs_pkg::RST_BRAKE_OPEN, 0);
        acc(1, CLS, swbs_pkg::RST_BRAKE_CLOSE, 0);
        acc(1, TOL, swbs_pkg::RST_SPEED_TOL, 0);
        acc(1, WIN, swbs_pkg::RST_SETTLE_TIME, 0);
        acc(1, MOV, swbs_pkg::RST_SETTLE_MOVE, 0);
        acc(1, CUR, 16'h0000, 0);
        repeat (4) begin
            r = 16'($urandom_range(65535, 1));
            acc(0, TOL, r, 0);
            acc(1, TOL, r, 0);
        end
        // opening with a 2 ms release delay, no settle move
        acc(0, OPN, 16'h0002, 0);
        acc(0, CLS, 16'h0003, 0);
        acc(0, MOV, 16'h0000, 0);
        acc(0, TOL, 16'h0064, 0);
        dev_cmd = 17'h00064;
        i_enable_req = 1'b1;
        @(negedge i_clk);
        wait_out(BR, 1, 2);
        check({16'h0, outs[ST]}, 17'h00001);
        hold(SE, 0, 8);
        wait_out(SE, 1, 25);
        hold(SM, 0, 30);
        acc(1, CUR, 16'h0123, 0);
        pulse(0);
        hold(BR, 1, 3);
        // speed window: qualify, leave band at the edge, requalify
        acc(0, WIN, 16'h0003, 0);
        hold(SR, 0, 15);
        wait_out(SR, 1, 40);
        dev_cmd = 17'h00065;
        wait_out(SR, 0, 3);
        dev_cmd = 17'($urandom_range(100, 0));
        hold(SR, 0, 15);
        wait_out(SR, 1, 40);
        acc(0, WIN, 16'h0004, 0);
        wait_out(SR, 0, 3);
        wait_out(SR, 1, 55);
        acc(0, WIN, 16'h0000, 0);
        wait_out(SR, 0, 3);
        hold(SR, 0, 60);
        // closing: brake at once, current kept, panel ignored
        i_enable_req = 1'b0;
        @(negedge i_clk);
        wait_out(BR, 0, 2);
        pulse(1);
        hold(BR, 0, 3);
        hold(SE, 1, 12);
        wait_out(SE, 0, 25);
        check({16'h0, outs[ST]}, 17'h00000);
        pulse(1);
        wait_out(BR, 1, 3);
        pulse(0);
        wait_out(BR, 0, 3);
        // zero release delay with settle move, then safe torque off
        acc(0, OPN, 16'h0000, 0);
        acc(0, MOV, 16'h0001, 0);
        i_enable_req = 1'b1;
        wait_out(SE, 1, 5);
        wait_out(SM, 1, 35);
        i_safe_torque_off = 1'b1;
        wait_out(SE, 0, 4);
        check({16'h0, outs[BR]}, 17'h00000);
        check({16'h0, outs[SM]}, 17'h00000);
        check({16'h0, outs[ST]}, 17'h00000);
        // pin stays high long enough for the checker's five-cycle window
        hold(SE, 0, 5);
        i_enable_req = 1'b0;
        i_safe_torque_off = 1'b0;
        repeat (5) @(negedge i_clk);
        finish_test();
    end
endmodule

/* sim/swbs_monitor.sv */
// port checker for the speed window and brake sequencer
// assumes one clock and a synchronous active-high reset
`timescale 1ns/1ps
module swbs_monitor (
    input wire logic i_clk, // clock
    input wire logic i_rst, // reset
    input wire swbs_pkg::swbs_req_t i_req, // access
    input wire swbs_pkg::swbs_rsp_t o_rsp, // answer
    input wire logic [16:0] i_speed_dev, // deviation
    input wire logic i_enable_req, // enable
    input wire logic i_safe_torque_off, // sto pin
    input wire logic i_manual_release, // panel
    input wire logic o_speed_reached, // reached
    input wire logic o_brake_release, // brake open
    input wire logic o_stage_enable, // current on
    input wire logic o_settle_move // settling
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_rst);
    // above 65535 rpm no tolerance can hold it in band
    chk_dev_out: assert property (i_speed_dev[16] |=> !o_speed_reached)
        else $error("reached while far out of band");
    // one spare cycle beyond the two-flop synchroniser
    chk_sto_cut: assert property (i_safe_torque_off [*5]
        |-> !o_stage_enable && !o_brake_release)
        else $error("current kept under safe torque off");
    chk_open_first: assert property ($rose(o_stage_enable) |-> o_brake_release)
        else $error("stage on with brake applied");
    chk_brake_lead: assert property ($rose(o_brake_release) |-> !o_stage_enable)
        else $error("brake opened after stage");
    chk_apply_now: assert property (o_brake_release && o_stage_enable && !i_enable_req
        |=> !o_brake_release)
        else $error("brake not applied on disable");
    chk_manual_ignored: assert property (o_stage_enable && !o_brake_release
        && !i_enable_req && i_manual_release |=> !o_brake_release)
        else $error("manual release taken while stage on");
    chk_settle_live: assert property (o_settle_move
        |-> o_stage_enable && o_brake_release)
        else $error("settle move without stage");
    chk_ack_due: assert property ((i_req.wr || i_req.rd) |=> o_rsp.ack)
        else $error("access not answered");
    chk_rdata_idle: assert property (!o_rsp.ack |-> o_rsp.rdata == 16'h0000)
        else $error("read data outside answer");
    cov_reached: cover property ($rose(o_speed_reached));
    cov_stage_off: cover property ($fell(o_stage_enable));
    cov_settle: cover property ($rose(o_settle_move));
endmodule
bind swbs_top swbs_monitor swbs_monitor_inst (
    .i_clk(i_clk), .i_rst(i_rst), .i_req(i_req), .o_rsp(o_rsp),
    .i_speed_dev(i_speed_dev), .i_enable_req(i_enable_req),
    .i_safe_torque_off(i_safe_torque_off), .i_manual_release(i_manual_release),
    .o_speed_reached(o_speed_reached), .o_brake_release(o_brake_release),
    .o_stage_enable(o_stage_enable), .o_settle_move(o_settle_move)
);

/* sim/swbs_stage_model.sv */
// power stage and holding brake stand-in
// assumes the bench sets the speed error of a running motor
`timescale 1ns/1ps
module swbs_stage_model (
    input wire logic i_clk, // clock
    input wire logic i_stage_enable, // current on
    input wire logic i_brake_release, // brake open
    input wire logic [16:0] i_dev_cmd, // error while running
    output logic [16:0] o_speed_dev, // to the block
    output logic [15:0] o_current // to the block
);
    initial begin
        o_speed_dev = 17'h1FFFF;
        o_current = 16'h0000;
    end
    // a held or unpowered shaft is far off any reference
    always @(negedge i_clk) begin
        o_speed_dev <= (i_stage_enable && i_brake_release) ? i_dev_cmd : 17'h1FFFF;
        o_current <= i_stage_enable ? 16'h0123 : 16'h0000;
    end
endmodule
